// *** logic/ep0_pkg.sv ***
// Package: constants and carriers for the endpoint-zero request block
package ep0_pkg;

    // SETUP request codes
    localparam logic [7:0] TYPE_OUT_DEV    = 8'h00;
    localparam logic [7:0] TYPE_IN_DEV     = 8'h80;
    localparam logic [7:0] TYPE_IN_IFC     = 8'h81;
    localparam logic [7:0] REQ_SET_ADDR    = 8'h05;
    localparam logic [7:0] REQ_GET_CFG     = 8'h08;
    localparam logic [7:0] REQ_SET_CFG     = 8'h09;
    localparam logic [7:0] REQ_GET_IFC     = 8'h0A;
    localparam logic [7:0] REQ_SET_IFC     = 8'h0B;
    localparam logic [15:0] LEN_ZERO       = 16'h0000;
    localparam logic [15:0] LEN_ONE        = 16'h0001;

    // Register byte addresses on APB
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_SETUP_LO   = 8'h08;
    localparam logic [7:0] ADDR_SETUP_HI   = 8'h0C;
    localparam logic [7:0] ADDR_FADDR      = 8'h10;
    localparam logic [7:0] ADDR_EP0_DATA   = 8'h14;
    localparam logic [7:0] ADDR_EP0_COUNT  = 8'h18;
    localparam logic [7:0] ADDR_EP1_CS     = 8'h1C;
    localparam logic [7:0] ADDR_EP1_COUNT  = 8'h20;
    localparam logic [7:0] ADDR_CFG        = 8'h24;

    // Field positions
    localparam int CTRL_OWNER_BIT   = 0;
    localparam int CTRL_NAK_BIT     = 1;
    localparam int CTRL_REENUM_BIT  = 2;
    localparam int EP1_BUSY_BIT     = 0;
    localparam int EP1_TOGGLE_BIT   = 1;

    localparam logic [6:0]  ADDR_DEFAULT  = 7'h00;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
    localparam int          NUM_IFC       = 4;
    localparam logic [6:0]  COUNT_ONE     = 7'h01;

    // Decoded SETUP packet
    typedef struct packed {
        logic [7:0]  req_type;
        logic [7:0]  request;
        logic [15:0] value;
        logic [15:0] index;
        logic [15:0] length;
    } setup_pkt_t;

    // Token seen on the USB side
    typedef struct packed {
        logic [6:0] addr;
        logic [3:0] endp;
        logic       is_setup;
        logic       is_in;
        logic       is_out;
    } token_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WAIT   = 2'b01,
        ST_STATUS = 2'b11
    } ctl_state_t;

endpackage : ep0_pkg

// *** logic/addr_filter.sv ***
// Function-address holder and token address match
`timescale 1ns/1ps
module addr_filter
    import ep0_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       bus_reset,
    input  wire logic       reenum_pulse,
    input  wire logic       addr_load,
    input  wire logic [6:0] addr_new,
    input  wire logic [6:0] tok_addr,
    output logic      [6:0] func_addr,
    output logic            addr_match
);

    // Loaded only by hardware; the processor can only clear it, through the re-enumeration bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_addr <= ADDR_DEFAULT;
        end else if (bus_reset || reenum_pulse) begin // RULE11 RULE13
            func_addr <= ADDR_DEFAULT;
        end else if (addr_load) begin // RULE10 RULE12
            func_addr <= addr_new;
        end
    end

    assign addr_match = (tok_addr == func_addr); // RULE9 RULE14

    addr_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        (bus_reset || reenum_pulse) |=> func_addr == ADDR_DEFAULT) // RULE13
        else $error("address not cleared");
    addr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(bus_reset || reenum_pulse || addr_load)
        |=> $stable(func_addr)) // RULE11
        else $error("address changed without cause");

endmodule : addr_filter

// *** logic/setup_decode.sv ***
// Classifies a SETUP packet into the handled standard requests
`timescale 1ns/1ps
module setup_decode
    import ep0_pkg::*;
(
    input  setup_pkt_t pkt,
    output logic       is_set_cfg,
    output logic       is_get_cfg,
    output logic       is_set_ifc,
    output logic       is_get_ifc,
    output logic       is_set_addr
);

    function automatic logic match(input setup_pkt_t p,
                                   input logic [7:0] t,
                                   input logic [7:0] r,
                                   input logic [15:0] l);
        match = (p.req_type == t) && (p.request == r) && (p.length == l);
    endfunction : match

    assign is_set_cfg  = match(pkt, TYPE_OUT_DEV, REQ_SET_CFG, LEN_ZERO);
    assign is_get_cfg  = match(pkt, TYPE_IN_DEV, REQ_GET_CFG, LEN_ONE);
    assign is_set_ifc  = match(pkt, TYPE_OUT_DEV, REQ_SET_IFC, LEN_ZERO);
    assign is_get_ifc  = match(pkt, TYPE_IN_IFC, REQ_GET_IFC, LEN_ONE);
    assign is_set_addr = match(pkt, TYPE_OUT_DEV, REQ_SET_ADDR, LEN_ZERO);

endmodule : setup_decode

// *** logic/ep0_requests.sv ***
// Endpoint-zero standard request handling with APB register access
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ep0_requests
    import ep0_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bus_reset,
    input  wire logic        tok_valid,
    input  token_t           tok,
    input  wire logic        setup_valid,
    input  setup_pkt_t       setup_pkt,
    output logic             tok_accept,
    output logic             hs_ack,
    output logic             hs_nak,
    output logic             zlp_send,
    output logic             in_data_valid,
    output logic      [7:0]  in_data,
    output logic             req_owner,
    output logic      [6:0]  dev_addr
);

    ////////////////////////////////////////////////////////////////////////
    // Behaviour
    // RULE1: host sets configuration, firmware stores it
    // RULE2: firmware ends set-config by clearing handshake NAK
    // RULE3: host then sets interface alternate settings
    // RULE4: get-config: buffer, count one, clear NAK
    // RULE5: set-interface selects alternate setting per interface
    // RULE6: set-interface: operate, reset toggles, re-arm, clear
    // RULE7: clear busy, write count to re-arm
    // RULE8: get-interface returns alternate setting, clears NAK
    // RULE9: fresh device answers only address zero
    // RULE10: hardware captures assigned address automatically
    // RULE11: address holds until reset or detach
    // RULE12: function address read-only from processor
    // RULE13: re-enumeration forces address to zero
    // RULE14: hardware filters on captured address
    // RULE15: owner bit picks default logic or firmware
    // RULE16: zero-length status NAKed until NAK cleared
    ////////////////////////////////////////////////////////////////////////

    logic             request_owner_select;
    logic             handshake_nak_bit;
    logic [7:0]       cfg_value;
    logic [7:0]       alternate_setting_number [NUM_IFC];
    logic [7:0]       ep_zero_buffer;
    logic [6:0]       ep_zero_byte_count;
    logic [1:0]       ep_one_ctrl_status;
    logic [6:0]       ep_one_count;
    setup_pkt_t       last_setup;
    ctl_state_t       state;
    logic             pend_addr;
    logic [6:0]       addr_new;
    logic             addr_load;
    logic             reenum_pulse;
    logic             addr_match;
    logic [6:0]       func_addr;
    logic             is_set_cfg;
    logic             is_get_cfg;
    logic             is_set_ifc;
    logic             is_get_ifc;
    logic             is_set_addr;
    logic             wr;
    logic             rd;
    logic             hit_ep0;
    logic             status_tok;
    logic [1:0]       ifc_sel;

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    setup_decode u_dec (
        .pkt         (setup_pkt),
        .is_set_cfg  (is_set_cfg),
        .is_get_cfg  (is_get_cfg),
        .is_set_ifc  (is_set_ifc),
        .is_get_ifc  (is_get_ifc),
        .is_set_addr (is_set_addr)
    );

    addr_filter u_addr (
        .pclk        (pclk),
        .presetn     (presetn),
        .bus_reset   (bus_reset),
        .reenum_pulse (reenum_pulse),
        .addr_load   (addr_load),
        .addr_new    (addr_new),
        .tok_addr    (tok.addr),
        .func_addr   (func_addr),
        .addr_match  (addr_match)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign hit_ep0 = tok_valid && addr_match && (tok.endp == 4'h0);
    assign status_tok = hit_ep0 && (state == ST_STATUS)
                        && (last_setup.req_type[7] ? tok.is_out : tok.is_in);
    assign ifc_sel = last_setup.index[1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable
                       && !(paddr[1:0] == 2'b00 && paddr <= ADDR_CFG);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= WORD_ZERO;
        end else if (rd) begin
            if (paddr == ADDR_CTRL)
                prdata <= {29'd0, request_owner_select & 1'b0,
                           handshake_nak_bit, request_owner_select};
            else if (paddr == ADDR_STATUS)
                prdata <= {30'd0, state};
            else if (paddr == ADDR_SETUP_LO)
                prdata <= {last_setup.value, last_setup.request,
                           last_setup.req_type};
            else if (paddr == ADDR_SETUP_HI)
                prdata <= {last_setup.length, last_setup.index};
            else if (paddr == ADDR_FADDR)
                prdata <= {25'd0, func_addr}; // RULE14
            else if (paddr == ADDR_EP0_DATA)
                prdata <= {24'd0, ep_zero_buffer};
            else if (paddr == ADDR_EP0_COUNT)
                prdata <= {25'd0, ep_zero_byte_count};
            else if (paddr == ADDR_EP1_CS)
                prdata <= {30'd0, ep_one_ctrl_status};
            else if (paddr == ADDR_EP1_COUNT)
                prdata <= {25'd0, ep_one_count};
            else if (paddr == ADDR_CFG)
                prdata <= {24'd0, cfg_value};
            else
                prdata <= WORD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_owner_select <= 1'b0;
        end else if (wr && paddr == ADDR_CTRL) begin // RULE15
            request_owner_select <= pwdata[CTRL_OWNER_BIT];
        end
    end

    assign reenum_pulse = wr && (paddr == ADDR_CTRL)
                          && pwdata[CTRL_REENUM_BIT]; // RULE13

    // NAK armed by a new SETUP when firmware is owner, cleared otherwise; set wins over a firmware clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            handshake_nak_bit <= 1'b0;
        end else if (bus_reset) begin
            handshake_nak_bit <= 1'b0;
        end else if (setup_valid && hit_ep0) begin
            handshake_nak_bit <= request_owner_select;
        end else if (wr && paddr == ADDR_CTRL
                     && pwdata[CTRL_NAK_BIT]) begin // RULE2 RULE4 RULE8
            handshake_nak_bit <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_setup <= '0;
        end else if (setup_valid && hit_ep0) begin
            last_setup <= setup_pkt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and alternate settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_value <= BYTE_ZERO;
        end else if (bus_reset) begin
            cfg_value <= BYTE_ZERO;
        end else if (wr && paddr == ADDR_CFG) begin // RULE1
            cfg_value <= pwdata[7:0];
        end else if (setup_valid && hit_ep0 && is_set_cfg
                     && !request_owner_select) begin // RULE1 RULE15
            cfg_value <= setup_pkt.value[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_IFC; i++)
                alternate_setting_number[i] <= BYTE_ZERO;
        end else if (bus_reset || (setup_valid && hit_ep0 && is_set_cfg)) begin
            for (int i = 0; i < NUM_IFC; i++) // RULE3
                alternate_setting_number[i] <= BYTE_ZERO;
        end else if (setup_valid && hit_ep0 && is_set_ifc) begin // RULE5
            alternate_setting_number[setup_pkt.index[1:0]] <=
                setup_pkt.value[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Endpoint buffers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ep_zero_buffer     <= BYTE_ZERO;
            ep_zero_byte_count <= 7'h00;
        end else if (wr && paddr == ADDR_EP0_DATA) begin // RULE4
            ep_zero_buffer <= pwdata[7:0];
        end else if (wr && paddr == ADDR_EP0_COUNT) begin // RULE4
            ep_zero_byte_count <= pwdata[6:0];
        end else if (setup_valid && hit_ep0 && !request_owner_select) begin
            ep_zero_byte_count <= COUNT_ONE;
            ep_zero_buffer <= is_get_cfg ? cfg_value
                : alternate_setting_number[setup_pkt.index[1:0]]; // RULE8
        end
    end

    // Busy and toggle take the written value; set-interface resets toggle and sets busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ep_one_ctrl_status <= 2'b00;
            ep_one_count       <= 7'h00;
        end else if (setup_valid && hit_ep0 && is_set_ifc) begin // RULE6
            ep_one_ctrl_status[EP1_TOGGLE_BIT] <= 1'b0;
            ep_one_ctrl_status[EP1_BUSY_BIT]   <= 1'b1;
        end else if (wr && paddr == ADDR_EP1_CS) begin // RULE7
            ep_one_ctrl_status <= pwdata[1:0];
        end else if (wr && paddr == ADDR_EP1_COUNT) begin // RULE7
            ep_one_count <= pwdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control transfer sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else if (bus_reset) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (setup_valid && hit_ep0)
                        state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (!handshake_nak_bit) // RULE16
                        state <= ST_STATUS;
                end
                ST_STATUS: begin
                    if (status_tok)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_addr <= 1'b0;
            addr_new  <= ADDR_DEFAULT;
        end else if (bus_reset) begin
            pend_addr <= 1'b0;
        end else if (setup_valid && hit_ep0 && is_set_addr) begin
            pend_addr <= 1'b1;
            addr_new  <= setup_pkt.value[6:0];
        end else if (status_tok) begin
            pend_addr <= 1'b0;
        end
    end

    // Address takes effect after status completes, at the old address
    assign addr_load = pend_addr && status_tok; // RULE10

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tok_accept    <= 1'b0;
            hs_ack        <= 1'b0;
            hs_nak        <= 1'b0;
            zlp_send      <= 1'b0;
            in_data_valid <= 1'b0;
            in_data       <= BYTE_ZERO;
        end else begin
            tok_accept    <= tok_valid && addr_match; // RULE9 RULE14
            hs_ack        <= (setup_valid && hit_ep0) || status_tok;
            hs_nak        <= hit_ep0 && !setup_valid
                             && (state == ST_WAIT); // RULE16
            zlp_send      <= status_tok && tok.is_in; // RULE16
            in_data_valid <= hit_ep0 && tok.is_in && state == ST_STATUS
                             && last_setup.req_type[7]; // RULE4 RULE8
            in_data       <= ep_zero_buffer;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_owner <= 1'b0;
            dev_addr  <= ADDR_DEFAULT;
        end else begin
            req_owner <= request_owner_select;
            dev_addr  <= func_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    nak_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_WAIT && handshake_nak_bit) |=> state == ST_WAIT) // RULE16
        else $error("status left while NAK set");
    nak_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_CTRL && pwdata[CTRL_NAK_BIT] && !bus_reset
         && !(setup_valid && hit_ep0)) |=> !handshake_nak_bit) // RULE2
        else $error("NAK bit not cleared");
    accept_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        tok_accept |-> $past(tok.addr) == $past(func_addr)) // RULE9
        else $error("token accepted at wrong address");
    cfg_auto_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_valid && hit_ep0 && is_set_cfg && !request_owner_select
         && !bus_reset && !(wr && paddr == ADDR_CFG))
        |=> cfg_value == $past(setup_pkt.value[7:0])) // RULE1
        else $error("configuration not stored");
    owner_nak_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_valid && hit_ep0 && !bus_reset)
        |=> handshake_nak_bit == $past(request_owner_select)) // RULE15
        else $error("owner select ignored");
    ifc_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_valid && hit_ep0 && is_set_ifc)
        |=> !ep_one_ctrl_status[EP1_TOGGLE_BIT]) // RULE6
        else $error("toggle not reset");
    busy_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_EP1_CS && !pwdata[EP1_BUSY_BIT]
         && !(setup_valid && hit_ep0 && is_set_ifc))
        |=> !ep_one_ctrl_status[EP1_BUSY_BIT]) // RULE7
        else $error("busy not cleared");
    addr_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        addr_load |=> ##1 dev_addr == $past(addr_new, 2)) // RULE10
        else $error("address not captured");
    get_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_EP0_COUNT) |=>
        ep_zero_byte_count == $past(pwdata[6:0])) // RULE4
        else $error("byte count not written");
    ifc_store_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_valid && hit_ep0 && is_set_ifc && !bus_reset)
        |=> alternate_setting_number[$past(setup_pkt.index[1:0])]
            == $past(setup_pkt.value[7:0])) // RULE5 RULE8
        else $error("alternate setting not stored");

    setup_c: cover property (@(posedge pclk) setup_valid && hit_ep0);
    status_c: cover property (@(posedge pclk) status_tok);
    addr_c: cover property (@(posedge pclk) addr_load);
    reenum_c: cover property (@(posedge pclk) reenum_pulse);

endmodule : ep0_requests

// *** sim/usb_host_model.sv ***
// Behavioural USB host: sends tokens and collects handshakes
`timescale 1ns/1ps
module usb_host_model
    import ep0_pkg::*;
(
    input  wire logic       pclk,
    output logic            tok_valid,
    output token_t          tok,
    output logic            setup_valid,
    output setup_pkt_t      setup_pkt,
    input  wire logic       tok_accept,
    input  wire logic       hs_ack,
    input  wire logic       hs_nak,
    input  wire logic       zlp_send,
    input  wire logic       in_data_valid,
    input  wire logic [7:0] in_data
);
    initial begin
        tok_valid   = 1'b0;
        tok         = '0;
        setup_valid = 1'b0;
        setup_pkt   = '0;
    end
    // Kind 0 setup, 1 in, 2 out; answer read in the cycle after
    task automatic xfer(input logic [6:0] a, input logic [1:0] kind,
                        input setup_pkt_t p, output logic [12:0] r);
        @(posedge pclk);
        tok_valid   <= 1'b1;
        tok         <= '{a, 4'h0, kind == 2'd0, kind == 2'd1, kind == 2'd2};
        setup_valid <= kind == 2'd0;
        setup_pkt   <= p;
        @(posedge pclk);
        tok_valid   <= 1'b0;
        setup_valid <= 1'b0;
        tok         <= ~tok; // No stale token on an idle bus
        setup_pkt   <= ~p;
        @(negedge pclk);
        r = {tok_accept, hs_ack, hs_nak, zlp_send, in_data_valid, in_data};
    endtask : xfer
endmodule : usb_host_model

// *** sim/tb_usb_ep0_config_address_requests.sv ***
// Self-checking bench for the endpoint-zero request block
`timescale 1ns/1ps
module tb_usb_ep0_config_address_requests import ep0_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        bus_reset, tok_valid, setup_valid, tok_accept, hs_ack;
    logic        hs_nak, zlp_send, in_data_valid, req_owner, slv_err;
    logic [7:0]  paddr, in_data;
    logic [31:0] pwdata, prdata, seed, q;
    logic [6:0]  dev_addr, cur_addr, a;
    logic [12:0] r;
    token_t      tok;
    setup_pkt_t  setup_pkt;
    int          error_cnt, n_tests;
    ep0_requests dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_reset(bus_reset), .tok_valid(tok_valid), .tok(tok),
        .setup_valid(setup_valid), .setup_pkt(setup_pkt),
        .tok_accept(tok_accept), .hs_ack(hs_ack), .hs_nak(hs_nak),
        .zlp_send(zlp_send), .in_data_valid(in_data_valid),
        .in_data(in_data), .req_owner(req_owner), .dev_addr(dev_addr));
    usb_host_model host_u (.pclk(pclk), .tok_valid(tok_valid), .tok(tok),
        .setup_valid(setup_valid), .setup_pkt(setup_pkt),
        .tok_accept(tok_accept), .hs_ack(hs_ack), .hs_nak(hs_nak),
        .zlp_send(zlp_send), .in_data_valid(in_data_valid),
        .in_data(in_data));
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [3:0] hs(input logic ack, nak, zlp);
        return {1'b1, ack, nak, zlp};
    endfunction : hs
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Full control transfer with firmware acting over APB
    task automatic ctl(input setup_pkt_t p, input logic [7:0] d);
        logic in_req;
        in_req = p.req_type[7];
        host_u.xfer(cur_addr, 2'd0, p, r);
        chk("setup hs", 32'(r[12:9]), 32'(hs(1, 0, 0)));
        host_u.xfer(cur_addr, 2'd1, p, r);
        chk("held off", 32'(r[12:9]), 32'(hs(0, 1, 0)));
        if (in_req) begin
            apb(1'b1, ADDR_EP0_DATA, {24'h00_0000, d}, q);
            apb(1'b1, ADDR_EP0_COUNT, 32'h0000_0001, q);
        end
        if (p.request == REQ_SET_IFC) begin
            apb(1'b1, ADDR_EP1_CS, WORD_ZERO, q);
            apb(1'b1, ADDR_EP1_COUNT, {24'h00_0000, d}, q);
        end
        if (p.request == REQ_SET_CFG)
            apb(1'b1, ADDR_CFG, {24'h0, d}, q);
        apb(1'b1, ADDR_CTRL, 32'h0000_0003, q);
        host_u.xfer(cur_addr, 2'd1, p, r);
        if (in_req) begin
            chk("in data", 32'(r[8:0]), {23'h0, 1'b1, d});
            host_u.xfer(cur_addr, 2'd2, p, r);
            chk("out status", 32'(r[12:9]), 32'(hs(1, 0, 0)));
        end else begin
            chk("in status", 32'(r[12:9]), 32'(hs(1, 0, 1)));
        end
    endtask : ctl
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        error_cnt++;
        test_done;
    end
    initial begin
        {presetn, psel, penable, pwrite, bus_reset} = '0;
        paddr = '0;
        pwdata = '0;
        error_cnt = 0;
        n_tests = 0;
        seed = 32'h0000_ca9f;
        cur_addr = ADDR_DEFAULT;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_FADDR, WORD_ZERO, q);
        chk("faddr reset", q, WORD_ZERO);
        host_u.xfer(7'h05, 2'd0, '0, r);
        chk("foreign token", 32'(r[12]), WORD_ZERO);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001, q);
        repeat (2) @(negedge pclk);
        chk("owner", 32'(req_owner), 32'h0000_0001);
        for (int i = 0; i < NUM_IFC; i++) begin
            seed = lfsr(seed);
            ctl('{TYPE_OUT_DEV, REQ_SET_CFG, {8'h00, seed[7:0]}, 16'h0000,
                LEN_ZERO}, seed[7:0]);
            ctl('{TYPE_IN_DEV, REQ_GET_CFG, 16'h0000, 16'h0000, LEN_ONE},
                seed[7:0]);
            ctl('{TYPE_OUT_DEV, REQ_SET_IFC, {8'h00, seed[15:8]}, 16'(i),
                LEN_ZERO}, seed[15:8]);
            ctl('{TYPE_IN_IFC, REQ_GET_IFC, 16'h0000, 16'(i), LEN_ONE},
                seed[15:8]);
        end
        apb(1'b1, ADDR_CTRL, WORD_ZERO, q);
        repeat (2) @(negedge pclk);
        chk("owner off", 32'(req_owner), WORD_ZERO);
        host_u.xfer(cur_addr, 2'd0, '{TYPE_OUT_DEV, REQ_SET_CFG,
            {8'h00, seed[7:0]}, 16'h0000, LEN_ZERO}, r);
        host_u.xfer(cur_addr, 2'd1, '0, r);
        chk("auto status", 32'(r[12:9]), 32'(hs(1, 0, 1)));
        apb(1'b0, ADDR_CFG, WORD_ZERO, q);
        chk("auto cfg", q, {24'h00_0000, seed[7:0]});
        for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            a = seed[6:0] | 7'h01;
            host_u.xfer(cur_addr, 2'd0, '{TYPE_OUT_DEV, REQ_SET_ADDR,
                {9'h000, a}, 16'h0000, LEN_ZERO}, r);
            host_u.xfer(cur_addr, 2'd1, '0, r);
            chk("addr status", 32'(r[12:9]), 32'(hs(1, 0, 1)));
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            chk("dev addr", 32'(dev_addr), 32'(a));
            cur_addr = a;
            apb(1'b1, ADDR_FADDR, 32'(~a), q);
            apb(1'b0, ADDR_FADDR, WORD_ZERO, q);
            chk("faddr ro", q, 32'(a));
            host_u.xfer(ADDR_DEFAULT, 2'd1, '0, r);
            chk("old addr", 32'(r[12]), WORD_ZERO);
            host_u.xfer(a, 2'd1, '0, r);
            chk("new addr", 32'(r[12]), 32'h0000_0001);
            if (k == 0) begin
                apb(1'b1, ADDR_CTRL, 32'h0000_0004, q);
            end else begin
                @(posedge pclk);
                bus_reset <= 1'b1;
                @(posedge pclk);
                bus_reset <= 1'b0;
            end
            apb(1'b0, ADDR_FADDR, WORD_ZERO, q);
            chk("addr cleared", q, WORD_ZERO);
            cur_addr = ADDR_DEFAULT;
        end
        apb(1'b0, 8'h28, WORD_ZERO, q);
        chk("slverr", 32'(slv_err), 32'h0000_0001);
        test_done;
    end
endmodule : tb_usb_ep0_config_address_requests
